// ### inc/light_ctl_pkg.sv
package light_ctl_pkg;
   // ------------------------------------------------------------
   // Operation control register layout
   // ------------------------------------------------------------
   localparam int RANGE_MSB     = 15;
   localparam int RANGE_LSB     = 12;
   localparam int DUR_BIT       = 11;
   localparam int MODE_MSB      = 10;
   localparam int MODE_LSB      = 9;
   localparam int OVF_BIT       = 8;
   localparam int DONE_BIT      = 7;
   localparam int ABOVE_BIT     = 6;
   localparam int BELOW_BIT     = 5;
   localparam int AUX_MSB       = 4;

   // Reset values
   localparam logic [3:0] RANGE_RST = 4'hc;
   localparam logic       DUR_RST   = 1'b1;
   localparam logic [1:0] MODE_RST  = 2'h0;
   localparam logic [4:0] AUX_RST   = 5'h10;

   // ------------------------------------------------------------
   // Codes
   // ------------------------------------------------------------
   localparam logic [3:0] RANGE_AUTO  = 4'hc;
   localparam logic [3:0] RANGE_TOP   = 4'hb;
   localparam logic [3:0] RANGE_FIRST = 4'h0;
   localparam logic [3:0] RANGE_FULL1 = 4'h5;
   localparam logic [3:0] RANGE_FULL2 = 4'h1;
   localparam logic [1:0] MODE_OFF    = 2'h0;
   localparam logic [1:0] MODE_SINGLE = 2'h1;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_KHZ      = 250000;
   localparam int CONV_SHORT_MS = 100;
   localparam int CONV_LONG_MS  = 800;
   localparam int CONV_SHORT_CYC = CONV_SHORT_MS * CLK_KHZ;
   localparam int CONV_LONG_CYC  = CONV_LONG_MS * CLK_KHZ;
endpackage

// ### inc/conv_timer_if.sv
`timescale 1ns/1ns
interface conv_timer_if;
   logic        start;
   logic [31:0] load;
   logic        expired;
   modport ctl (output start, output load, input expired);
   modport tmr (input start, input load, output expired);
endinterface

// ### hdl/conv_timer.sv
`timescale 1ns/1ns
module conv_timer
   import light_ctl_pkg::*;
(
   // Clock and reset
   input wire logic  ref_clk,
   input wire logic  reset,
   // Control side
   conv_timer_if.tmr tif
);
   logic [31:0] count_r;
   logic [31:0] count_nxt;
   logic        run_r;
   logic        run_nxt;

   // A start always reloads, so an abort plus restart needs no stop
   always_comb begin
      count_nxt = count_r;
      run_nxt   = run_r;
      if (tif.start) begin
         count_nxt = tif.load;
         run_nxt   = 1'b1;
      end else if (run_r) begin
         count_nxt = count_r - 32'h1;
         if (count_r == 32'h1) begin
            run_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         count_r <= 32'h0;
         run_r   <= 1'b0;
      end else begin
         count_r <= count_nxt;
         run_r   <= run_nxt;
      end
   end

   // One-cycle pulse on the last cycle of the interval; start is not looked at
   // here, since the control side derives start from this pulse (no comb loop)
   assign tif.expired = run_r && (count_r == 32'h1);
endmodule

// ### hdl/light_conv_ctl.sv
`timescale 1ns/1ns
module light_conv_ctl
   import light_ctl_pkg::*;
#(
   parameter int SHORT_CYC = CONV_SHORT_CYC,
   parameter int LONG_CYC  = CONV_LONG_CYC
)(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // Register port
   input  wire logic        cfg_wr,
   input  wire logic [15:0] cfg_wdata,
   input  wire logic        cfg_rd,
   output logic      [15:0] cfg_rdata,
   // Converter front end
   input  wire logic        fe_overload,
   input  wire logic [11:0] fe_count,
   output logic             fe_integrate,
   output logic      [3:0]  fe_range,
   output logic             fe_long,
   // Result
   output logic      [15:0] result_word
);
   typedef enum logic {st_idle, st_conv} conv_state_t;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   conv_state_t state_r, state_nxt;
   logic [3:0]  range_r, range_nxt;
   logic        dur_r, dur_nxt;
   logic [1:0]  mode_r, mode_nxt;
   logic        ovf_r, ovf_nxt;
   logic        done_r, done_nxt;
   logic [4:0]  aux_r, aux_nxt;
   logic [3:0]  act_r, act_nxt;
   logic        seen_r, seen_nxt;
   logic [15:0] result_r, result_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic        is_auto;
   logic        retry;
   logic        finish;
   logic [11:0] trimmed;
   logic [3:0]  start_range;

   conv_timer_if tif ();

   conv_timer u_timer (
      .ref_clk (ref_clk),
      .reset   (reset),
      .tif     (tif)
   );

   // Reserved codes above automatic are also run as automatic
   assign is_auto = (range_r >= RANGE_AUTO);

   // ------------------------------------------------------------
   // Conversion events
   // ------------------------------------------------------------
   // Raise and retry
   assign retry  = (state_r == st_conv) && tif.expired && is_auto
                   && (seen_r || fe_overload) && (act_r < RANGE_TOP);
   assign finish = (state_r == st_conv) && tif.expired && !retry;

   // Automatic search starts low; manual uses field
   assign start_range = is_auto ? RANGE_FIRST : range_r;

   // Short time trims noise bits at the low ranges
   always_comb begin
      trimmed = fe_count;
      if (!dur_r) begin
         if (act_r == RANGE_FIRST) begin
            trimmed = {fe_count[11:3], 3'h0};
         end else if (act_r >= RANGE_FULL2 && act_r < RANGE_FULL1) begin
            trimmed = {fe_count[11:2], 2'h0};
         end else if (act_r == RANGE_FULL1) begin
            trimmed = {fe_count[11:1], 1'h0};
         end
      end
   end

   // ------------------------------------------------------------
   // Next values
   // ------------------------------------------------------------
   always_comb begin
      state_nxt  = state_r;
      range_nxt  = range_r;
      dur_nxt    = dur_r;
      mode_nxt   = mode_r;
      ovf_nxt    = ovf_r;
      done_nxt   = done_r;
      aux_nxt    = aux_r;
      act_nxt    = act_r;
      seen_nxt   = seen_r || fe_overload;
      result_nxt = result_r;
      rdata_nxt  = rdata_r;
      tif.start  = 1'b0;
      tif.load   = dur_r ? 32'(LONG_CYC) : 32'(SHORT_CYC);

      case (state_r)
         st_idle: begin
            // Any non-off mode starts a conversion
            if (mode_r != MODE_OFF) begin
               tif.start = 1'b1;
               state_nxt = st_conv;
               act_nxt   = start_range;
               seen_nxt  = 1'b0;
            end
         end
         st_conv: begin
            if (retry) begin
               // Retry stops at the top range
               tif.start = 1'b1;
               act_nxt   = act_r + 4'h1;
               seen_nxt  = 1'b0;
            end else if (finish) begin
               // Manual range flags any overload seen
               // Automatic reaches here overloaded only at top
               ovf_nxt    = seen_r || fe_overload;
               result_nxt = {act_r, trimmed};
               done_nxt   = 1'b1;
               state_nxt  = st_idle;
               if (mode_r == MODE_SINGLE) begin
                  mode_nxt = MODE_OFF;
               end
            end
         end
         default: state_nxt = st_idle;
      endcase

      // Read answers with the flag, then clears it
      if (cfg_rd) begin
         rdata_nxt = {range_r, dur_r, mode_r, ovf_r, done_r, 2'h0, aux_r};
         if (!finish) begin
            done_nxt = 1'b0;
         end
      end

      // A write aborts; the idle state restarts if asked
      if (cfg_wr) begin
         range_nxt = cfg_wdata[RANGE_MSB:RANGE_LSB];
         dur_nxt   = cfg_wdata[DUR_BIT];
         mode_nxt  = cfg_wdata[MODE_MSB:MODE_LSB];
         aux_nxt   = cfg_wdata[AUX_MSB:0];
         state_nxt = st_idle;
         // Shutdown writes keep the done flag
         if (cfg_wdata[MODE_MSB:MODE_LSB] != MODE_OFF && !finish) begin
            done_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_r  <= st_idle;
         range_r  <= RANGE_RST;
         dur_r    <= DUR_RST;
         mode_r   <= MODE_RST;
         ovf_r    <= 1'b0;
         done_r   <= 1'b0;
         aux_r    <= AUX_RST;
         act_r    <= RANGE_FIRST;
         seen_r   <= 1'b0;
         result_r <= 16'h0;
         rdata_r  <= 16'h0;
      end else begin
         state_r  <= state_nxt;
         range_r  <= range_nxt;
         dur_r    <= dur_nxt;
         mode_r   <= mode_nxt;
         ovf_r    <= ovf_nxt;
         done_r   <= done_nxt;
         aux_r    <= aux_nxt;
         act_r    <= act_nxt;
         seen_r   <= seen_nxt;
         result_r <= result_nxt;
         rdata_r  <= rdata_nxt;
      end
   end

   // Outputs
   assign cfg_rdata    = rdata_r;
   assign result_word  = result_r;
   assign fe_integrate = (state_r == st_conv);
   assign fe_range     = act_r;
   assign fe_long      = dur_r;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   a_reset_state: assert property ($fell(reset) |->
      range_r == RANGE_AUTO && dur_r && mode_r == MODE_OFF && !ovf_r)
      else $error("bad reset values");
   a_mode_start: assert property (state_r == st_idle && mode_r != MODE_OFF
      && !cfg_wr |=> state_r == st_conv && act_r == $past(start_range))
      else $error("conversion did not start");
   a_single_return: assert property (finish && mode_r == MODE_SINGLE
      && !cfg_wr |=> mode_r == MODE_OFF ##1 state_r == st_idle)
      else $error("single shot did not return to off");
   a_flags_kept: assert property (cfg_wr && !cfg_rd && !finish
      && cfg_wdata[MODE_MSB:MODE_LSB] == MODE_OFF |=> done_r == $past(done_r))
      else $error("shutdown write changed done flag");
   a_auto_bound: assert property (is_auto && state_r == st_conv
      |-> act_r <= RANGE_TOP)
      else $error("automatic range above top");
   a_retry_step: assert property (retry && !cfg_wr
      |=> state_r == st_conv && act_r == $past(act_r) + 4'h1)
      else $error("retry did not raise range");
   a_auto_ovf: assert property (finish && is_auto && !cfg_wr
      |=> !ovf_r || result_word[15:12] == RANGE_TOP)
      else $error("automatic overflow below top");
   // A restarting write with no write behind it leaves one idle cycle, then the block converts
   a_write_abort: assert property (cfg_wr && cfg_wdata[MODE_MSB:MODE_LSB] != MODE_OFF
      ##1 !cfg_wr |-> state_r == st_idle ##1 state_r == st_conv)
      else $error("write did not restart");
   a_done_set: assert property (finish |=> done_r)
      else $error("done flag not set");
   a_short_trim: assert property (finish && !dur_r && act_r == RANGE_FIRST
      |=> result_word[2:0] == 3'h0)
      else $error("short conversion not trimmed");
   a_manual_exp: assert property (finish && !is_auto
      |=> result_word[15:12] == $past(range_r))
      else $error("manual exponent mismatch");

   c_single_done: cover property (finish && mode_r == MODE_SINGLE);
   c_auto_retry: cover property (retry ##[1:1000] finish);
   c_read_clear: cover property (done_r && cfg_rd ##1 !done_r);
   c_continuous: cover property (finish && mode_r[1] ##2 state_r == st_conv);
endmodule

// ### bench/light_front_end_model.sv
`timescale 1ns/1ns
// ----
// Front end stand-in: overloads while the range is below a threshold
// ----
module light_front_end_model (
   // From the block
   input  wire logic        fe_integrate,
   input  wire logic [3:0]  fe_range,
   // Scenario settings
   input  wire logic [3:0]  ovl_thr,
   input  wire logic [11:0] cnt_val,
   // To the block
   output logic             fe_overload,
   output logic      [11:0] fe_count
);
   // Idle count is inverted so a stale sample never looks right
   always_comb begin
      fe_overload = fe_integrate && (fe_range < ovl_thr);
      fe_count    = fe_integrate ? cnt_val : ~cnt_val;
   end
endmodule

// ### bench/test_light_conv_ctl.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module test_light_conv_ctl;
   import light_ctl_pkg::*;
   localparam int SC = 20;
   localparam int LC = 50;
   logic        ref_clk      = 1'b0;
   logic        reset        = 1'b1;
   logic        cfg_wr       = 1'b0;
   logic        cfg_rd       = 1'b0;
   logic [15:0] cfg_wdata    = 16'h0000;
   logic [3:0]  ovl_thr      = 4'h0;
   logic [11:0] cnt_val      = 12'h000;
   logic [31:0] rng          = 32'h0000e9cf;
   logic [15:0] cfg_rdata;
   logic        fe_overload;
   logic [11:0] fe_count;
   logic        fe_integrate;
   logic [3:0]  fe_range;
   logic        fe_long;
   logic [15:0] result_word;
   int          num_errors   = 0;
   int          total_checks = 0;
   // ----
   // Instances
   // ----
   light_conv_ctl #(.SHORT_CYC(SC), .LONG_CYC(LC)) i_light_conv_ctl (
      .ref_clk, .reset, .cfg_wr, .cfg_wdata, .cfg_rd, .cfg_rdata, .fe_overload,
      .fe_count, .fe_integrate, .fe_range, .fe_long, .result_word);
   light_front_end_model i_light_front_end_model (
      .fe_integrate, .fe_range, .ovl_thr, .cnt_val, .fe_overload, .fe_count);
   // 250 MHz clock
   always #2 ref_clk = ~ref_clk;
   // ----
   // Helpers
   // ----
   function automatic logic [31:0] nxt_rand();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   // Short conversions lose low bits at the finer ranges
   function automatic logic [15:0] exp_res(logic [3:0] r, logic d, logic [11:0] c);
      logic [11:0] m;
      m = 12'hfff;
      if (!d && r == 4'h5) m = 12'hffe;
      else if (!d && r != 4'h0 && r < 4'h5) m = 12'hffc;
      else if (!d && r == 4'h0) m = 12'hff8;
      return {r, c & m};
   endfunction
   task automatic print_verdict();
      if (num_errors == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Bounded wait on the converting flag, counting cycles
   task automatic wait_int(logic v, output int n);
      n = 0;
      while (fe_integrate !== v) begin
         @(negedge ref_clk);
         n++;
         if (n > 3000) begin
            num_errors++;
            print_verdict();
         end
      end
   endtask
   task automatic wr(logic [15:0] d);
      cfg_wdata = d;
      cfg_wr = 1'b1;
      @(negedge ref_clk);
      cfg_wr = 1'b0;
   endtask
   task automatic rd(output logic [15:0] d);
      cfg_rd = 1'b1;
      @(negedge ref_clk);
      cfg_rd = 1'b0;
      d = cfg_rdata;
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      logic [15:0] v;
      logic [3:0]  r;
      logic [3:0]  fr;
      logic        d;
      logic        ov;
      int          n;
      repeat (16) @(negedge ref_clk);
      reset = 1'b0;
      `CHK("reset idle", 1'b0, fe_integrate)
      `CHK("reset result", 16'h0000, result_word)
      rd(v);
      `CHK("reset value", 16'hc810, v)
      for (int i = 0; i < 20; i++) begin
         r = (i < 13) ? 4'(i) : RANGE_AUTO;
         void'(nxt_rand());
         // Corner case: first pass is the short time at the finest range
         d = (i == 0) ? 1'b0 : rng[0];
         cnt_val = rng[12:1];
         ovl_thr = (i == 19) ? 4'hc : rng[19:16] % 4'hd;
         fr = (r == RANGE_AUTO) ? ((ovl_thr > RANGE_TOP) ? RANGE_TOP : ovl_thr) : r;
         ov = (r == RANGE_AUTO) ? (ovl_thr > RANGE_TOP) : (r < ovl_thr);
         wr({r, d, MODE_SINGLE, 9'h010});
         wait_int(1'b1, n);
         `CHK("duration", d, fe_long)
         `CHK("range used", (r == RANGE_AUTO) ? RANGE_FIRST : r, fe_range)
         rd(v);
         `CHK("busy mode", MODE_SINGLE, v[10:9])
         wait_int(1'b0, n);
         repeat (3) @(negedge ref_clk);
         `CHK("stays off", 1'b0, fe_integrate)
         `CHK("result", exp_res(fr, d, cnt_val), result_word)
         if (i[0]) wr({r, d, MODE_OFF, 9'h010});
         rd(v);
         `CHK("done read", {r, d, MODE_OFF, ov, 1'b1, 7'h10}, v)
         // Let an edge pass so the read strobe is not raised where it just fell
         @(negedge ref_clk);
         rd(v);
         `CHK("done cleared", 1'b0, v[7])
      end
      ovl_thr = 4'h0;
      for (int m = 2; m < 4; m++) begin
         wr({4'h7, 1'b0, 2'(m), 9'h010});
         wait_int(1'b1, n);
         repeat (5) @(negedge ref_clk);
         wr({4'h7, 1'b0, 2'(m), 9'h010});
         `CHK("abort", 1'b0, fe_integrate)
         @(negedge ref_clk);
         `CHK("restart", 1'b1, fe_integrate)
         wait_int(1'b0, n);
         `CHK("conv length", SC, n)
         @(negedge ref_clk);
         `CHK("continues", 1'b1, fe_integrate)
         rd(v);
         `CHK("cont read", {4'h7, 1'b0, 2'(m), 2'b01, 7'h10}, v)
      end
      print_verdict();
   end
endmodule
